// file: hdl/scsi_host_adapter_bridge.sv
`timescale 1ns/1ps
`default_nettype none
`include "scsi_bridge_consts.svh"
module scsi_host_adapter_bridge #(
	parameter int BUF_DEPTH = `BUF_DEPTH_DEF
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic host_system_reset_n,
	input wire logic host_timing_strobe,
	input wire logic page_select_n,
	input wire logic read_not_write,
	input wire logic [7:0] host_addr,
	input wire scsi_bridge_pkg::byte_t host_data_in,
	output scsi_bridge_pkg::byte_t host_data_out,
	output logic host_data_oe,
	output logic host_interrupt_request_n,
	output logic host_irq_oe,
	input wire logic scsi_req_n,
	input wire logic scsi_bsy_n,
	input wire logic scsi_io_n,
	input wire logic scsi_cd_n,
	input wire logic scsi_msg_n,
	input wire scsi_bridge_pkg::byte_t scsi_db_in,
	output scsi_bridge_pkg::byte_t scsi_db_out,
	output logic scsi_db_oe,
	output logic scsi_ack_n,
	output logic scsi_sel_n
);
	import scsi_bridge_pkg::*;

	if (BUF_DEPTH != 2) begin : g_chk
		$error("write path buffer must hold exactly two entries");
	end

	// host timing and page select
	logic strobe_q;
	logic clean_page_select_n_q;
	logic fired_q;
	wire strobe_rise = host_timing_strobe & ~strobe_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strobe_q <= 1'b0;
			clean_page_select_n_q <= 1'b1;
		end else if (clk_en) begin
			strobe_q <= host_timing_strobe;
			if (strobe_rise) begin
				clean_page_select_n_q <= page_select_n;
			end
		end
	end

	// address decode
	wire addr_hit = host_addr[7:2] == `WIN_BASE;
	wire dec_en = addr_hit & ~clean_page_select_n_q & host_timing_strobe & strobe_q;
	wire dec_sel_t dec_sel = {~read_not_write, host_addr[1:0]};
	wire read_data_strobe_n = ~(dec_en & (dec_sel == `DEC_READ_DATA));
	wire write_data_strobe_n = ~(dec_en & (dec_sel == `DEC_WRITE_DATA));
	wire status_strobe_n = ~(dec_en & (dec_sel == `DEC_STATUS));
	wire select_strobe_n = ~(dec_en & (dec_sel == `DEC_SELECT));
	wire irq_enable_strobe_n = ~(dec_en & (dec_sel == `DEC_IRQ_ENABLE));

	// one event per access phase
	wire access_pulse = dec_en & ~fired_q;
	wire rd_pulse = access_pulse & ~read_data_strobe_n;
	wire wr_pulse = access_pulse & ~write_data_strobe_n;
	wire sel_pulse = access_pulse & ~select_strobe_n;
	wire ien_pulse = access_pulse & ~irq_enable_strobe_n;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fired_q <= 1'b0;
		end else if (clk_en) begin
			fired_q <= dec_en;
		end
	end

	// write path through the two-entry buffer
	byte_stream_if #(.W(8)) wr_in ();
	byte_stream_if #(.W(8)) wr_out ();
	assign wr_in.valid = wr_pulse;
	assign wr_in.data = host_data_in;
	assign wr_out.ready = scsi_io_n;
	wire wr_accept = wr_pulse & wr_in.ready;

	byte_buffer #(.W(8), .DEPTH(BUF_DEPTH)) u_wr_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.in_s(wr_in),
		.out_s(wr_out)
	);

	byte_t wr_latch_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_latch_q <= `BYTE_RST;
		end else if (clk_en && wr_out.valid && wr_out.ready) begin
			wr_latch_q <= wr_out.data;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scsi_db_out <= ~`BYTE_RST;
			scsi_db_oe <= 1'b0;
		end else if (clk_en) begin
			scsi_db_out <= ~wr_latch_q;
			scsi_db_oe <= ~read_not_write & scsi_io_n;
		end
	end

	// acknowledge handshake
	wire ack_clear = ~host_system_reset_n | scsi_req_n;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scsi_ack_n <= 1'b1;
		end else if (clk_en) begin
			if (ack_clear) begin
				scsi_ack_n <= 1'b1;
			end else if (rd_pulse | wr_accept) begin
				scsi_ack_n <= 1'b0;
			end
		end
	end

	// selection handshake
	wire sel_clear = ~host_system_reset_n | ~scsi_bsy_n;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scsi_sel_n <= 1'b1;
		end else if (clk_en) begin
			if (sel_clear) begin
				scsi_sel_n <= 1'b1;
			end else if (sel_pulse) begin
				scsi_sel_n <= 1'b0;
			end
		end
	end

	// interrupt
	logic irq_en_q;
	logic req_n_q;
	wire req_fall = req_n_q & ~scsi_req_n;
	wire irq_set = irq_en_q & req_fall;
	wire irq_drop = ~irq_en_q | ~host_system_reset_n;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_en_q <= `IRQ_EN_RST;
			req_n_q <= 1'b1;
		end else if (clk_en) begin
			req_n_q <= scsi_req_n;
			if (~host_system_reset_n) begin
				irq_en_q <= `IRQ_EN_RST;
			end else if (ien_pulse) begin
				irq_en_q <= host_data_in[0];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_interrupt_request_n <= 1'b1;
			host_irq_oe <= 1'b0;
		end else if (clk_en) begin
			if (irq_set && host_system_reset_n) begin
				host_interrupt_request_n <= 1'b0;
				host_irq_oe <= 1'b1;
			end else if (irq_drop) begin
				host_interrupt_request_n <= 1'b1;
				host_irq_oe <= 1'b0;
			end
		end
	end

	// read path and status
	status_t status_live;
	assign status_live.unused = 3'h0;
	assign status_live.msg = ~scsi_msg_n;
	assign status_live.cd = ~scsi_cd_n;
	assign status_live.io = ~scsi_io_n;
	assign status_live.bsy = ~scsi_bsy_n;
	assign status_live.req = ~scsi_req_n;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_data_out <= `BYTE_RST;
			host_data_oe <= 1'b0;
		end else if (clk_en) begin
			host_data_oe <= ~read_data_strobe_n | ~status_strobe_n;
			if (~read_data_strobe_n) begin
				host_data_out <= ~scsi_db_in;
			end else if (~status_strobe_n) begin
				host_data_out <= status_live;
			end
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_DECODE_WINDOW: assert property (access_pulse |-> addr_hit && !clean_page_select_n_q && host_timing_strobe)
		else $error("strobe fired outside window");
	AST_ONE_PULSE: assert property (clk_en && access_pulse |=> !access_pulse)
		else $error("second strobe in one access");
	AST_ACK_SET: assert property (clk_en && rd_pulse && !ack_clear |=> !scsi_ack_n)
		else $error("data read did not acknowledge");
	AST_ACK_CLR: assert property (clk_en && scsi_req_n |=> scsi_ack_n)
		else $error("acknowledge held without request");
	AST_SEL_SET: assert property (clk_en && sel_pulse && !sel_clear |=> !scsi_sel_n)
		else $error("select write did not select");
	AST_SEL_CLR: assert property (clk_en && !scsi_bsy_n |=> scsi_sel_n)
		else $error("select held while busy");
	AST_IRQ_RAISE: assert property (clk_en && irq_set && host_system_reset_n |=> !host_interrupt_request_n && host_irq_oe)
		else $error("interrupt missed on request fall");
	AST_IRQ_OFF: assert property (clk_en && !irq_en_q |=> host_interrupt_request_n && !host_irq_oe)
		else $error("interrupt while disabled");
	AST_READ_INV: assert property (clk_en && !read_data_strobe_n |=> host_data_oe && host_data_out == ~$past(scsi_db_in))
		else $error("read byte not inverted bus byte");
	AST_STATUS_BSY: assert property (clk_en && !status_strobe_n && !scsi_bsy_n |=> host_data_out[`ST_BSY_BIT])
		else $error("busy missing from status");
	AST_DB_OE: assert property (clk_en |=> scsi_db_oe == $past(!read_not_write && scsi_io_n))
		else $error("bus drive enable wrong");
	AST_HOST_RST: assert property (clk_en && !host_system_reset_n |=> scsi_ack_n && scsi_sel_n && !irq_en_q)
		else $error("host reset left state pending");

	COV_ACK: cover property (clk_en && rd_pulse ##1 !scsi_ack_n ##[1:50] scsi_ack_n);
	COV_SEL: cover property (clk_en && sel_pulse ##1 !scsi_sel_n ##[1:50] scsi_sel_n);
	COV_IRQ: cover property (clk_en && irq_set ##1 !host_interrupt_request_n);
	COV_BUF_FULL: cover property (!wr_in.ready);
endmodule // scsi_host_adapter_bridge
`default_nettype wire

// file: hdl/scsi_bridge_consts.svh
// Function
// - page select cleaned at timing strobe edge
// - exactly four byte locations answered
// - low address window gates final decoder
// - five active-low strobes from offset, direction
// - data port access sets acknowledge
// - request withdrawal clears acknowledge
// - select write sets select, busy clears
// - enable bit arms interrupt on request fall
// - write byte held after strobe ends
// - inverted write byte driven when io high during a host write
// - inverted bus byte returned on data read
// - control lines latched on status read
// - busy indication at status bit one
// - interrupt pin open-collector, active low, level
`ifndef SCSI_BRIDGE_CONSTS_SVH
`define SCSI_BRIDGE_CONSTS_SVH

`define HOST_PAGE 8'hfc
`define DATA_PORT_ADDR 16'hfc40
`define BUS_STATUS_ADDR 16'hfc41
`define TARGET_SELECT_ADDR 16'hfc42
`define INTERRUPT_ENABLE_ADDR 16'hfc43
`define WIN_BASE 6'h10
`define DEC_READ_DATA 3'h0
`define DEC_STATUS 3'h1
`define DEC_WRITE_DATA 3'h4
`define DEC_SELECT 3'h6
`define DEC_IRQ_ENABLE 3'h7
`define ST_REQ_BIT 0
`define ST_BSY_BIT 1
`define ST_IO_BIT 2
`define ST_CD_BIT 3
`define ST_MSG_BIT 4
`define IRQ_EN_RST 1'b0
`define BYTE_RST 8'h00
`define BUF_DEPTH_DEF 2

`endif

// file: hdl/scsi_bridge_pkg.sv
package scsi_bridge_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [2:0] dec_sel_t;
	typedef struct packed {
		logic [2:0] unused;
		logic msg;
		logic cd;
		logic io;
		logic bsy;
		logic req;
	} status_t;
endpackage

// file: hdl/byte_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// file: hdl/byte_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module byte_buffer #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	byte_stream_if.snk in_s,
	byte_stream_if.src out_s
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("byte_buffer depth must be a power of two, at least 2");
	end

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire push = in_s.valid & in_s.ready;
	wire pop = out_s.valid & out_s.ready;

	assign in_s.ready = count_q != (AW + 1)'(DEPTH);
	assign out_s.valid = count_q != '0;
	assign out_s.data = mem_q[rd_ptr_q];

	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			mem_q[wr_ptr_q] <= in_s.data;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (clk_en) begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule // byte_buffer
`default_nettype wire

// file: test/scsi_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module scsi_target_model (
	input wire logic clk,
	input wire logic scsi_ack_n,
	input wire logic scsi_sel_n,
	input wire logic answer_sel,
	output logic req_n,
	output logic bsy_n,
	output logic io_n,
	output logic cd_n,
	output logic msg_n,
	output scsi_bridge_pkg::byte_t db
);
	import scsi_bridge_pkg::*;
	initial begin
		req_n = 1'b1;
		bsy_n = 1'b1;
		io_n = 1'b1;
		cd_n = 1'b1;
		msg_n = 1'b1;
		db = 8'hff;
	end
	// answer selection by raising busy, kept up afterwards
	always begin
		@(posedge clk);
		if (!scsi_sel_n && bsy_n && io_n && answer_sel) begin
			repeat (3) @(posedge clk);
			bsy_n <= 1'b0;
		end
	end
	// one byte: request first, drop after acknowledge, then release the bus (pulled up)
	task automatic xfer(input logic dir_in, input byte_t d, input int hold, output logic got);
		@(posedge clk);
		io_n <= ~dir_in;
		db <= dir_in ? d : 8'hff;
		got = 1'b0;
		repeat (4) @(posedge clk);
		req_n <= 1'b0;
		for (int i = 0; i < 500 && !got; i++) begin
			@(posedge clk);
			got = !scsi_ack_n;
		end
		repeat (hold) @(posedge clk);
		req_n <= 1'b1;
		@(posedge clk);
		db <= 8'hff;
		io_n <= 1'b1;
	endtask
endmodule // scsi_target_model
`default_nettype wire

// file: test/scsi_host_adapter_bridge_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module scsi_host_adapter_bridge_tb;
	import scsi_bridge_pkg::*;
	logic clk = 0, sys_rst = 1, host_system_reset_n = 1, host_timing_strobe = 0;
	logic page_select_n = 1, read_not_write = 1, answer_sel = 0;
	logic [7:0] host_addr = 8'h00;
	byte_t host_data_in = 8'h00, host_data_out, scsi_db_in, scsi_db_out, model_db, rd;
	logic host_data_oe, host_interrupt_request_n, host_irq_oe, scsi_db_oe, scsi_ack_n, scsi_sel_n;
	logic scsi_req_n, scsi_bsy_n, scsi_io_n, scsi_cd_n, scsi_msg_n;
	logic oe_seen, dboe_seen, ack_seen, sel_seen, got;
	int failures = 0, cmp_count = 0;
	always #2.5 clk = ~clk;
	always begin
		repeat (100) @(negedge clk);
		host_timing_strobe = ~host_timing_strobe;
	end
	assign scsi_db_in = model_db & (scsi_db_oe ? scsi_db_out : 8'hff);
	scsi_host_adapter_bridge u_scsi_host_adapter_bridge (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
		.host_system_reset_n(host_system_reset_n), .host_timing_strobe(host_timing_strobe),
		.page_select_n(page_select_n), .read_not_write(read_not_write), .host_addr(host_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.host_interrupt_request_n(host_interrupt_request_n), .host_irq_oe(host_irq_oe),
		.scsi_req_n(scsi_req_n), .scsi_bsy_n(scsi_bsy_n), .scsi_io_n(scsi_io_n), .scsi_cd_n(scsi_cd_n),
		.scsi_msg_n(scsi_msg_n), .scsi_db_in(scsi_db_in), .scsi_db_out(scsi_db_out),
		.scsi_db_oe(scsi_db_oe), .scsi_ack_n(scsi_ack_n), .scsi_sel_n(scsi_sel_n));
	scsi_target_model u_scsi_target_model (.clk(clk), .scsi_ack_n(scsi_ack_n), .scsi_sel_n(scsi_sel_n),
		.answer_sel(answer_sel), .req_n(scsi_req_n), .bsy_n(scsi_bsy_n), .io_n(scsi_io_n),
		.cd_n(scsi_cd_n), .msg_n(scsi_msg_n), .db(model_db));
	// one host access over a whole timing strobe high phase
	task automatic acc(input logic rnw, input logic [15:0] a, input byte_t d);
		@(negedge host_timing_strobe);
		page_select_n = (a[15:8] !== 8'hfc);
		host_addr = a[7:0];
		read_not_write = rnw;
		host_data_in = d;
		{oe_seen, dboe_seen, ack_seen, sel_seen} = 4'h0;
		@(posedge host_timing_strobe);
		for (int i = 0; i < 99; i++) begin
			@(negedge clk);
			if (i == 4) rd = host_data_out;
			oe_seen |= host_data_oe;
			dboe_seen |= scsi_db_oe;
			ack_seen |= ~scsi_ack_n;
			sel_seen |= ~scsi_sel_n;
		end
		@(negedge host_timing_strobe);
		page_select_n = 1'b1;
		read_not_write = 1'b1;
	endtask
	task automatic t_reset;
		`CHK(scsi_ack_n, 1'b1)
		`CHK(scsi_sel_n, 1'b1)
		`CHK(host_interrupt_request_n, 1'b1)
		`CHK(host_data_oe, 1'b0)
	endtask
	task automatic t_unmapped;
		fork
			u_scsi_target_model.xfer(1'b1, 8'h11, 0, got);
			acc(1'b1, 16'hfc44, 8'h00);
		join
		`CHK(oe_seen, 1'b0)
		`CHK(ack_seen, 1'b0)
		fork
			u_scsi_target_model.xfer(1'b1, 8'h11, 0, got);
			acc(1'b1, 16'hfd40, 8'h00);
		join
		`CHK(oe_seen, 1'b0)
		`CHK(ack_seen, 1'b0)
	endtask
	task automatic t_host_rst;
		acc(1'b0, 16'hfc42, 8'h00);
		`CHK(scsi_sel_n, 1'b0)
		@(negedge clk) host_system_reset_n = 1'b0;
		@(negedge clk) host_system_reset_n = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(scsi_sel_n, 1'b1)
	endtask
	task automatic t_select;
		answer_sel = 1'b1;
		acc(1'b0, 16'hfc42, 8'h00);
		`CHK(sel_seen, 1'b1)
		`CHK(scsi_sel_n, 1'b1)
		acc(1'b1, 16'hfc41, 8'h00);
		`CHK(rd, 8'h02)
		`CHK(oe_seen, 1'b1)
	endtask
	task automatic t_read(input byte_t d);
		fork
			u_scsi_target_model.xfer(1'b1, d, 20, got);
			acc(1'b1, 16'hfc40, 8'h00);
		join
		repeat (3) @(negedge clk);
		`CHK(rd, ~d)
		`CHK(got, 1'b1)
		`CHK(scsi_ack_n, 1'b1)
	endtask
	task automatic t_write;
		fork
			u_scsi_target_model.xfer(1'b0, 8'h00, 0, got);
			acc(1'b0, 16'hfc40, 8'h3c);
		join
		`CHK(got, 1'b1)
		`CHK(dboe_seen, 1'b1)
		`CHK(scsi_db_out, 8'hc3)
		`CHK(scsi_ack_n, 1'b1)
	endtask
	task automatic t_irq;
		acc(1'b0, 16'hfc43, 8'h01);
		t_read(8'h77);
		`CHK(host_interrupt_request_n, 1'b0)
		`CHK(host_irq_oe, 1'b1)
		acc(1'b0, 16'hfc43, 8'hfe);
		repeat (3) @(negedge clk);
		`CHK(host_interrupt_request_n, 1'b1)
		`CHK(host_irq_oe, 1'b0)
	endtask
	task automatic finish_test;
		if (failures == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_unmapped();
		t_host_rst();
		t_select();
		t_read(8'h5a);
		`CHK(host_interrupt_request_n, 1'b1)
		t_write();
		t_irq();
		finish_test();
	end
	initial begin
		#200000;
		failures++;
		finish_test();
	end
endmodule // scsi_host_adapter_bridge_tb
`default_nettype wire
